// ===== design/asi_irq_top.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
// Function
// - Set transmit timeout flag when outgoing transfer stalls past the configured limit.
// - Set receive timeout flag when incoming transfer stalls past the configured limit.
// - Set transmit empty flag while outgoing FIFO holds nothing.
// - Set transmit full flag while outgoing FIFO cannot accept more.
// - Set receive empty flag while incoming FIFO holds nothing.
// - Set receive full flag while incoming FIFO has no room.
// - Set refill request flag when outgoing level falls to almost-empty threshold.
// - Set drain request flag when incoming level reaches almost-full threshold.
// - Set total end-of-frame flag when whole outgoing chain is consumed.
// - Set descriptors exhausted flag when incoming chain has no valid descriptor.
// - Set outbound descriptor error flag on an invalid descriptor.
// - Set inbound descriptor error flag on an invalid descriptor.
// - Set outbound end-of-frame flag per finished end-of-frame descriptor.
// - Set outbound done flag after all buffered outgoing data is read.
// - Set inbound frame complete flag when expected reception finishes.
// - Set inbound done flag each time current descriptor is handled.
// - Latch outgoing descriptor address of last end of frame, read only.
// - Latch incoming descriptor address of last end of frame, read only.
// - Expose outgoing buffer address of last end of frame, read only.
// - Expose current and next inbound descriptor and next buffer addresses.
// - Expose current and next outbound descriptor and next buffer addresses.
module asi_irq_top (
   input  wire logic                   SYS_CLK_I,
   input  wire logic                   SRST_I,
   input  wire logic                   HSEL_I,
   input  wire logic [31:0]            HADDR_I,
   input  wire logic [1:0]             HTRANS_I,
   input  wire logic                   HWRITE_I,
   input  wire logic [2:0]             HSIZE_I,
   input  wire logic [31:0]            HWDATA_I,
   input  wire logic                   HREADY_I,
   output logic [31:0]                 HRDATA_O,
   output logic                        HREADYOUT_O,
   output logic                        HRESP_O,
   input  wire asi_pkg::asi_fifo_t     FIFO_I,
   input  wire asi_pkg::asi_dma_evt_t  DMA_EVT_I,
   input  wire asi_pkg::asi_dma_addr_t DMA_ADDR_I,
   output logic [31:0]                 CTRL_O,
   output logic [31:0]                 FIFO_SETUP_O,
   output logic [31:0]                 TX_CHAIN_O,
   output logic [31:0]                 RX_CHAIN_O,
   output logic                        IRQ_O
);
   import asi_pkg::*;

   logic                  wr_pend_q;
   logic [5:0]            wr_idx_q;
   logic [31:0]           rdata_q;
   logic [31:0]           rw_mem_q [0:63];
   logic [FLAG_COUNT-1:0] raw_q;
   logic [FLAG_COUNT-1:0] raw_d;
   logic [FLAG_COUNT-1:0] ena_q;
   logic [FLAG_COUNT-1:0] set_vec;
   logic [FLAG_COUNT-1:0] clr_vec;
   logic [FLAG_COUNT-1:0] masked;
   logic [31:0]           tx_eof_desc_q;
   logic [31:0]           tx_eof_buf_q;
   logic [31:0]           rx_eof_desc_q;
   asi_dma_addr_t         addr_q;
   logic [1:0]            tmo_hit;
   logic                  addr_ok;
   logic [5:0]            a_idx;
   logic [5:0]            wr_idx_clr;
   logic [6:0]            tx_ae_thresh;
   logic [6:0]            rx_af_thresh;
   logic [6:0]            tx_level_prev_q;
   logic [6:0]            rx_level_prev_q;

   // Storage words that software may write and read back
   function automatic logic is_rw(input logic [5:0] idx);
      logic [31:0] a;
      a = {REG_BLOCK_BASE, idx, 2'b00};
      is_rw = (a == MAIN_CONTROL_ADDR) || (a == SIGNAL_DELAY_TIMING_ADDR) ||
              (a == FIFO_SETUP_ADDR) || (a == RX_FRAME_WORD_COUNT_ADDR) ||
              (a == STATIC_CHANNEL_VALUE_ADDR) || (a == CHANNEL_SETUP_ADDR) ||
              (a == TX_CHAIN_CONTROL_ADDR) || (a == RX_CHAIN_CONTROL_ADDR) ||
              (a == DMA_SETUP_ADDR) || (a == STALL_TIMEOUT_SETUP_ADDR) ||
              (a == PCM_SETUP_ADDR) || (a == POWER_DOWN_CONTROL_ADDR) ||
              (a == ADC_LCD_CAMERA_SETUP_ADDR) || (a == BIT_CLOCK_SETUP_ADDR) ||
              (a == SAMPLE_RATE_SETUP_ADDR) || (a == DENSITY_MOD_SETUP_ADDR) ||
              (a == DENSITY_MOD_RATES_ADDR);
   endfunction

   function automatic logic [31:0] reset_of(input logic [5:0] idx);
      logic [31:0] a;
      a = {REG_BLOCK_BASE, idx, 2'b00};
      if (a == FIFO_SETUP_ADDR) begin
         reset_of = FIFO_SETUP_RESET;
      end else if (a == STALL_TIMEOUT_SETUP_ADDR) begin
         reset_of = TIMEOUT_RESET;
      end else begin
         reset_of = WORD_RESET;
      end
   endfunction

   // AHB address phase decode
   assign addr_ok     = HADDR_I[31:8] == REG_BLOCK_BASE;
   assign a_idx       = HADDR_I[7:2];
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = 1'b0;
   assign HRDATA_O    = rdata_q;

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 6'h00;
      end else begin
         wr_pend_q <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I && addr_ok;
         wr_idx_q  <= a_idx;
      end
   end

   // Read data captured in the address phase, stands in the data phase
   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         rdata_q <= WORD_RESET;
      end else if (HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I) begin
         rdata_q <= WORD_RESET;
         if (addr_ok) begin
            unique case (HADDR_I)
               IRQ_RAW_FLAGS_ADDR:      rdata_q <= {16'h0000, raw_q};
               IRQ_MASKED_FLAGS_ADDR:   rdata_q <= {16'h0000, masked};
               IRQ_ENABLES_ADDR:        rdata_q <= {16'h0000, ena_q};
               TX_EOF_DESC_ADDR_ADDR:   rdata_q <= tx_eof_desc_q;
               RX_EOF_DESC_ADDR_ADDR:   rdata_q <= rx_eof_desc_q;
               TX_EOF_BUFFER_ADDR_ADDR: rdata_q <= tx_eof_buf_q;
               RX_CURRENT_DESC_ADDR:    rdata_q <= addr_q.rx_current_desc;
               RX_NEXT_DESC_ADDR:       rdata_q <= addr_q.rx_next_desc;
               RX_NEXT_BUFFER_ADDR:     rdata_q <= addr_q.rx_next_buffer;
               TX_CURRENT_DESC_ADDR:    rdata_q <= addr_q.tx_current_desc;
               TX_NEXT_DESC_ADDR:       rdata_q <= addr_q.tx_next_desc;
               TX_NEXT_BUFFER_ADDR:     rdata_q <= addr_q.tx_next_buffer;
               DMA_RX_STATE_ADDR:       rdata_q <= addr_q.rx_state;
               DMA_TX_STATE_ADDR:       rdata_q <= addr_q.tx_state;
               UNIT_STATE_ADDR:         rdata_q <= addr_q.unit_state;
               default: begin
                  if (is_rw(a_idx)) begin
                     rdata_q <= rw_mem_q[a_idx];
                  end
               end
            endcase
         end
      end
   end

   // Plain read/write storage
   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         for (int i = 0; i < 64; i++) begin
            rw_mem_q[i] <= reset_of(6'(i));
         end
      end else if (wr_pend_q && is_rw(wr_idx_q)) begin
         rw_mem_q[wr_idx_q] <= HWDATA_I;
      end
   end

   assign CTRL_O       = rw_mem_q[MAIN_CONTROL_ADDR[7:2]];
   assign FIFO_SETUP_O = rw_mem_q[FIFO_SETUP_ADDR[7:2]];
   assign TX_CHAIN_O   = rw_mem_q[TX_CHAIN_CONTROL_ADDR[7:2]];
   assign RX_CHAIN_O   = rw_mem_q[RX_CHAIN_CONTROL_ADDR[7:2]];

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         ena_q <= '0;
      end else if (wr_pend_q && wr_idx_q == IRQ_ENABLES_ADDR[7:2]) begin
         ena_q <= HWDATA_I[FLAG_COUNT-1:0];
      end
   end

   // DMA address trackers
   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         addr_q <= '0;
      end else begin
         addr_q <= DMA_ADDR_I;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         tx_eof_desc_q <= WORD_RESET;
         tx_eof_buf_q  <= WORD_RESET;
      end else if (DMA_EVT_I.tx_eof) begin
         tx_eof_desc_q <= DMA_ADDR_I.tx_eof_desc;
         tx_eof_buf_q  <= DMA_ADDR_I.tx_eof_buffer;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         rx_eof_desc_q <= WORD_RESET;
      end else if (DMA_EVT_I.rx_frame_complete) begin
         rx_eof_desc_q <= DMA_ADDR_I.rx_eof_desc;
      end
   end

   // Stall timeout counters, index 0 transmit, 1 receive
   for (genvar g = 0; g < 2; g++) begin : g_tmo
      logic [TIMEOUT_W-1:0] cnt_q;
      logic                 fired_q;
      logic                 en;
      logic                 pend;
      logic                 xfer;
      logic [TIMEOUT_W-1:0] thresh;

      assign thresh = rw_mem_q[STALL_TIMEOUT_SETUP_ADDR[7:2]][TIMEOUT_THRESH_LSB +: TIMEOUT_W];
      assign en     = rw_mem_q[STALL_TIMEOUT_SETUP_ADDR[7:2]][g == 0 ? TX_TIMEOUT_EN_BIT : RX_TIMEOUT_EN_BIT];
      assign pend   = (g == 0) ? FIFO_I.tx_pending : FIFO_I.rx_pending;
      assign xfer   = (g == 0) ? FIFO_I.tx_xfer : FIFO_I.rx_xfer;

      always_ff @(posedge SYS_CLK_I) begin
         if (SRST_I) begin
            cnt_q   <= '0;
            fired_q <= 1'b0;
         end else if (xfer || !pend || !en) begin
            cnt_q   <= '0;
            fired_q <= 1'b0;
         end else if (!fired_q) begin
            if (cnt_q >= thresh) begin
               fired_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end

      assign tmo_hit[g] = en && pend && !xfer && !fired_q && (cnt_q >= thresh);
   end

   assign tx_ae_thresh = FIFO_SETUP_O[TX_AE_THRESH_LSB +: FIFO_LEVEL_W];
   assign rx_af_thresh = FIFO_SETUP_O[RX_AF_THRESH_LSB +: FIFO_LEVEL_W];

   always_ff @(posedge SYS_CLK_I) begin
      // Follows the FIFO through reset too, so no false crossing after release
      tx_level_prev_q <= FIFO_I.tx_level;
      rx_level_prev_q <= FIFO_I.rx_level;
   end

   // Event sources
   always_comb begin
      set_vec                        = '0;
      set_vec[TX_TIMEOUT_BIT]        = tmo_hit[0];
      set_vec[RX_TIMEOUT_BIT]        = tmo_hit[1];
      set_vec[TX_FIFO_EMPTY_BIT]     = FIFO_I.tx_level == 7'h00;
      set_vec[TX_FIFO_FULL_BIT]      = FIFO_I.tx_level >= FIFO_DEPTH;
      set_vec[RX_FIFO_EMPTY_BIT]     = FIFO_I.rx_level == 7'h00;
      set_vec[RX_FIFO_FULL_BIT]      = FIFO_I.rx_level >= FIFO_DEPTH;
      set_vec[TX_REFILL_REQUEST_BIT] = (FIFO_I.tx_level <= tx_ae_thresh) &&
                                       (tx_level_prev_q > tx_ae_thresh);
      set_vec[RX_DRAIN_REQUEST_BIT]  = (FIFO_I.rx_level >= rx_af_thresh) &&
                                       (rx_level_prev_q < rx_af_thresh);
      set_vec[TX_TOTAL_EOF_BIT]      = DMA_EVT_I.tx_total_eof;
      set_vec[RX_DESC_EXHAUSTED_BIT] = DMA_EVT_I.rx_desc_exhausted;
      set_vec[TX_DESC_ERROR_BIT]     = DMA_EVT_I.tx_desc_error;
      set_vec[RX_DESC_ERROR_BIT]     = DMA_EVT_I.rx_desc_error;
      set_vec[TX_EOF_BIT]            = DMA_EVT_I.tx_eof;
      set_vec[TX_DONE_BIT]           = DMA_EVT_I.tx_done;
      set_vec[RX_FRAME_COMPLETE_BIT] = DMA_EVT_I.rx_frame_complete;
      set_vec[RX_DONE_BIT]           = DMA_EVT_I.rx_done;
   end

   // Sticky flags, a new event wins over a clear in the same cycle
   assign wr_idx_clr = IRQ_CLEAR_ADDR[7:2];
   assign clr_vec    = (wr_pend_q && wr_idx_q == wr_idx_clr) ? HWDATA_I[FLAG_COUNT-1:0] : '0;
   assign raw_d      = (raw_q & ~clr_vec) | set_vec;

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         raw_q <= '0;
      end else begin
         raw_q <= raw_d;
      end
   end

   assign masked = raw_q & ena_q;
   assign IRQ_O  = |masked;

endmodule

// ===== common/asi_pkg.sv
package asi_pkg;

   // Register byte addresses
   localparam logic [31:0] MAIN_CONTROL_ADDR         = 32'h3FF4F008;
   localparam logic [31:0] IRQ_RAW_FLAGS_ADDR        = 32'h3FF4F00C;
   localparam logic [31:0] IRQ_MASKED_FLAGS_ADDR     = 32'h3FF4F010;
   localparam logic [31:0] IRQ_ENABLES_ADDR          = 32'h3FF4F014;
   localparam logic [31:0] IRQ_CLEAR_ADDR            = 32'h3FF4F018;
   localparam logic [31:0] SIGNAL_DELAY_TIMING_ADDR  = 32'h3FF4F01C;
   localparam logic [31:0] FIFO_SETUP_ADDR           = 32'h3FF4F020;
   localparam logic [31:0] RX_FRAME_WORD_COUNT_ADDR  = 32'h3FF4F024;
   localparam logic [31:0] STATIC_CHANNEL_VALUE_ADDR = 32'h3FF4F028;
   localparam logic [31:0] CHANNEL_SETUP_ADDR        = 32'h3FF4F02C;
   localparam logic [31:0] TX_CHAIN_CONTROL_ADDR     = 32'h3FF4F030;
   localparam logic [31:0] RX_CHAIN_CONTROL_ADDR     = 32'h3FF4F034;
   localparam logic [31:0] TX_EOF_DESC_ADDR_ADDR     = 32'h3FF4F038;
   localparam logic [31:0] RX_EOF_DESC_ADDR_ADDR     = 32'h3FF4F03C;
   localparam logic [31:0] TX_EOF_BUFFER_ADDR_ADDR   = 32'h3FF4F040;
   localparam logic [31:0] RX_CURRENT_DESC_ADDR      = 32'h3FF4F048;
   localparam logic [31:0] RX_NEXT_DESC_ADDR         = 32'h3FF4F04C;
   localparam logic [31:0] RX_NEXT_BUFFER_ADDR       = 32'h3FF4F050;
   localparam logic [31:0] TX_CURRENT_DESC_ADDR      = 32'h3FF4F054;
   localparam logic [31:0] TX_NEXT_DESC_ADDR         = 32'h3FF4F058;
   localparam logic [31:0] TX_NEXT_BUFFER_ADDR       = 32'h3FF4F05C;
   localparam logic [31:0] DMA_SETUP_ADDR            = 32'h3FF4F060;
   localparam logic [31:0] DMA_RX_STATE_ADDR         = 32'h3FF4F06C;
   localparam logic [31:0] DMA_TX_STATE_ADDR         = 32'h3FF4F070;
   localparam logic [31:0] STALL_TIMEOUT_SETUP_ADDR  = 32'h3FF4F074;
   localparam logic [31:0] PCM_SETUP_ADDR            = 32'h3FF4F0A0;
   localparam logic [31:0] POWER_DOWN_CONTROL_ADDR   = 32'h3FF4F0A4;
   localparam logic [31:0] ADC_LCD_CAMERA_SETUP_ADDR = 32'h3FF4F0A8;
   localparam logic [31:0] BIT_CLOCK_SETUP_ADDR      = 32'h3FF4F0AC;
   localparam logic [31:0] SAMPLE_RATE_SETUP_ADDR    = 32'h3FF4F0B0;
   localparam logic [31:0] DENSITY_MOD_SETUP_ADDR    = 32'h3FF4F0B4;
   localparam logic [31:0] DENSITY_MOD_RATES_ADDR    = 32'h3FF4F0B8;
   localparam logic [31:0] UNIT_STATE_ADDR           = 32'h3FF4F0BC;
   localparam logic [23:0] REG_BLOCK_BASE            = 24'h3FF4F0;

   // Flag bit positions
   localparam int RX_DRAIN_REQUEST_BIT        = 0;
   localparam int TX_REFILL_REQUEST_BIT       = 1;
   localparam int RX_FIFO_FULL_BIT            = 2;
   localparam int RX_FIFO_EMPTY_BIT           = 3;
   localparam int TX_FIFO_FULL_BIT            = 4;
   localparam int TX_FIFO_EMPTY_BIT           = 5;
   localparam int RX_TIMEOUT_BIT              = 6;
   localparam int TX_TIMEOUT_BIT              = 7;
   localparam int RX_DONE_BIT                 = 8;
   localparam int RX_FRAME_COMPLETE_BIT       = 9;
   localparam int TX_DONE_BIT                 = 10;
   localparam int TX_EOF_BIT                  = 11;
   localparam int RX_DESC_ERROR_BIT           = 12;
   localparam int TX_DESC_ERROR_BIT           = 13;
   localparam int RX_DESC_EXHAUSTED_BIT       = 14;
   localparam int TX_TOTAL_EOF_BIT            = 15;
   localparam int FLAG_COUNT                  = 16;

   // Field layouts and sizes
   localparam int FIFO_LEVEL_W                = 7;
   localparam logic [6:0] FIFO_DEPTH          = 7'h40;
   localparam int TX_AE_THRESH_LSB            = 0;
   localparam int RX_AF_THRESH_LSB            = 7;
   localparam int TIMEOUT_W                   = 12;
   localparam int TIMEOUT_THRESH_LSB          = 0;
   localparam int TX_TIMEOUT_EN_BIT           = 12;
   localparam int RX_TIMEOUT_EN_BIT           = 13;

   // Reset values
   localparam logic [31:0] WORD_RESET         = 32'h00000000;
   localparam logic [31:0] FIFO_SETUP_RESET   = 32'h00000F84;
   localparam logic [31:0] TIMEOUT_RESET      = 32'h000030FF;

   typedef struct packed {
      logic [6:0] tx_level;
      logic [6:0] rx_level;
      logic       tx_pending;
      logic       rx_pending;
      logic       tx_xfer;
      logic       rx_xfer;
   } asi_fifo_t;

   typedef struct packed {
      logic tx_total_eof;
      logic rx_desc_exhausted;
      logic tx_desc_error;
      logic rx_desc_error;
      logic tx_eof;
      logic tx_done;
      logic rx_frame_complete;
      logic rx_done;
   } asi_dma_evt_t;

   typedef struct packed {
      logic [31:0] tx_eof_desc;
      logic [31:0] tx_eof_buffer;
      logic [31:0] rx_eof_desc;
      logic [31:0] rx_current_desc;
      logic [31:0] rx_next_desc;
      logic [31:0] rx_next_buffer;
      logic [31:0] tx_current_desc;
      logic [31:0] tx_next_desc;
      logic [31:0] tx_next_buffer;
      logic [31:0] rx_state;
      logic [31:0] tx_state;
      logic [31:0] unit_state;
   } asi_dma_addr_t;

endpackage

// ===== test/asi_irq_monitor.sv
`timescale 1ns/1ps
module asi_irq_monitor
   import asi_pkg::*;
(
   input wire logic                   SYS_CLK_I,
   input wire logic                   SRST_I,
   input wire logic                   HSEL_I,
   input wire logic [31:0]            HADDR_I,
   input wire logic [1:0]             HTRANS_I,
   input wire logic                   HWRITE_I,
   input wire logic [2:0]             HSIZE_I,
   input wire logic [31:0]            HWDATA_I,
   input wire logic                   HREADY_I,
   input wire logic [31:0]            HRDATA_O,
   input wire logic                   HREADYOUT_O,
   input wire logic                   HRESP_O,
   input wire asi_pkg::asi_fifo_t     FIFO_I,
   input wire asi_pkg::asi_dma_evt_t  DMA_EVT_I,
   input wire asi_pkg::asi_dma_addr_t DMA_ADDR_I,
   input wire logic [31:0]            CTRL_O,
   input wire logic [31:0]            FIFO_SETUP_O,
   input wire logic [31:0]            TX_CHAIN_O,
   input wire logic [31:0]            RX_CHAIN_O,
   input wire logic                   IRQ_O
);
   wire logic take   = HSEL_I & HTRANS_I[1] & HREADY_I;
   wire logic rd_raw = take & !HWRITE_I & (HADDR_I == IRQ_RAW_FLAGS_ADDR);
   wire logic rd_rcd = take & !HWRITE_I & (HADDR_I == RX_CURRENT_DESC_ADDR);
   wire logic rd_tcd = take & !HWRITE_I & (HADDR_I == TX_CURRENT_DESC_ADDR);
   wire logic wr_msk = take & HWRITE_I & (HADDR_I == IRQ_CLEAR_ADDR || HADDR_I == IRQ_ENABLES_ADDR);

   default clocking mon_cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (SRST_I);

   a_reset_irq_low: assert property (disable iff (1'b0) SRST_I |=> !IRQ_O)
      else $error("interrupt high after reset");
   a_irq_holds: assert property ($fell(IRQ_O) |-> $past(wr_msk, 2) || $past(SRST_I))
      else $error("interrupt dropped without clear or enable write");
   a_rx_cur_read: assert property (rd_rcd && $stable(DMA_ADDR_I.rx_current_desc) && !$past(SRST_I)
      |=> HRDATA_O == $past(DMA_ADDR_I.rx_current_desc)) else $error("rx current descriptor mismatch");
   a_tx_cur_read: assert property (rd_tcd && $stable(DMA_ADDR_I.tx_current_desc) && !$past(SRST_I)
      |=> HRDATA_O == $past(DMA_ADDR_I.tx_current_desc)) else $error("tx current descriptor mismatch");
   a_tx_empty_flag: assert property (rd_raw && FIFO_I.tx_level == 7'h00
      && $past(FIFO_I.tx_level) == 7'h00 && !$past(SRST_I) |=> HRDATA_O[TX_FIFO_EMPTY_BIT])
      else $error("tx empty flag missing");
   a_rx_empty_flag: assert property (rd_raw && FIFO_I.rx_level == 7'h00
      && $past(FIFO_I.rx_level) == 7'h00 && !$past(SRST_I) |=> HRDATA_O[RX_FIFO_EMPTY_BIT])
      else $error("rx empty flag missing");
   a_tx_full_flag: assert property (rd_raw && FIFO_I.tx_level == FIFO_DEPTH
      && $past(FIFO_I.tx_level) == FIFO_DEPTH && !$past(SRST_I) |=> HRDATA_O[TX_FIFO_FULL_BIT])
      else $error("tx full flag missing");
   a_rx_full_flag: assert property (rd_raw && FIFO_I.rx_level == FIFO_DEPTH
      && $past(FIFO_I.rx_level) == FIFO_DEPTH && !$past(SRST_I) |=> HRDATA_O[RX_FIFO_FULL_BIT])
      else $error("rx full flag missing");
   a_dma_evt_flags: assert property (rd_raw && !$past(SRST_I)
      |=> (HRDATA_O[15:8] & $past(DMA_EVT_I, 2)) == $past(DMA_EVT_I, 2))
      else $error("dma event flag missing");
endmodule

bind asi_irq_top asi_irq_monitor u_mon (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .HSEL_I(HSEL_I),
   .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
   .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .FIFO_I(FIFO_I),
   .DMA_EVT_I(DMA_EVT_I), .DMA_ADDR_I(DMA_ADDR_I), .CTRL_O(CTRL_O), .FIFO_SETUP_O(FIFO_SETUP_O),
   .TX_CHAIN_O(TX_CHAIN_O), .RX_CHAIN_O(RX_CHAIN_O), .IRQ_O(IRQ_O));

// ===== test/asi_irq_top_bench.sv
`timescale 1ns/1ps
module asi_irq_top_bench;
   import asi_pkg::*;
   logic          sys_clk    = 1'h0;
   logic          srst       = 1'h1;
   logic          hsel       = 1'h0;
   logic [31:0]   haddr      = 32'h00000000;
   logic [1:0]    htrans     = 2'h0;
   logic          hwrite     = 1'h0;
   logic [31:0]   hwdata     = 32'h00000000;
   wire  [31:0]   hrdata;
   wire           hready;
   wire           hresp;
   wire           irq;
   wire  [31:0]   ctrl;
   wire  [31:0]   fsetup;
   wire  [31:0]   txch;
   wire  [31:0]   rxch;
   asi_fifo_t     fifo       = '0;
   asi_dma_evt_t  evt        = '0;
   asi_dma_addr_t daddr      = '0;
   int            mismatches = 0;
   int            cmp_count  = 0;

   always #20 sys_clk = ~sys_clk;

   asi_irq_top dut (.SYS_CLK_I(sys_clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .FIFO_I(fifo), .DMA_EVT_I(evt), .DMA_ADDR_I(daddr),
      .CTRL_O(ctrl), .FIFO_SETUP_O(fsetup), .TX_CHAIN_O(txch), .RX_CHAIN_O(rxch), .IRQ_O(irq));

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'h1 && n < 50);
      if (hready !== 1'h1) begin
         mismatches++;
         final_report();
      end
   endtask

   // Single word transfer; request held until ready seen
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_ready();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      r = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'h1, a, d, r);
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'h0, a, 32'h00000000, r);
      check(r, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic reset_values();
      rdchk(FIFO_SETUP_ADDR, 32'h00000F84);
      rdchk(STALL_TIMEOUT_SETUP_ADDR, 32'h000030FF);
      rdchk(IRQ_ENABLES_ADDR, 32'h00000000);
      rdchk(32'h3FF4F044, 32'h00000000);
      check({31'h0, irq}, 32'h00000000);
      check({31'h0, hresp}, 32'h00000000);
      check(fsetup, 32'h00000F84);
      wr(IRQ_ENABLES_ADDR, 32'hFFFFFFFF);
      rdchk(IRQ_ENABLES_ADDR, 32'h0000FFFF);
      check({31'h0, irq}, 32'h00000001);
      wr(IRQ_ENABLES_ADDR, 32'h00000000);
      idle(1);
      check({31'h0, irq}, 32'h00000000);
   endtask

   task automatic fifo_flags();
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000028);
      fifo.tx_level <= 7'h40;
      fifo.rx_level <= 7'h40;
      idle(2);
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h0000003D);
      wr(IRQ_CLEAR_ADDR, 32'h0000FFFF);
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000014);
      fifo.tx_level <= 7'h05;
      fifo.rx_level <= 7'h1E;
      idle(2);
      wr(IRQ_CLEAR_ADDR, 32'h0000FFFF);
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000000);
      fifo.tx_level <= 7'h04;
      idle(2);
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000002);
      fifo.rx_level <= 7'h1F;
      idle(2);
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000003);
      wr(IRQ_CLEAR_ADDR, 32'h0000FFFF);
   endtask

   task automatic dma_flags();
      wr(IRQ_ENABLES_ADDR, 32'h00000800);
      daddr.tx_eof_desc <= 32'h0A0B0C00;
      daddr.tx_eof_buffer <= 32'h0D0E0F00;
      daddr.rx_eof_desc <= 32'h01020300;
      for (int i = 0; i < 8; i++) begin
         evt <= 8'h01 << i;
         @(posedge sys_clk);
         evt <= '0;
         rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000100 << i);
         check({31'h0, irq}, {31'h0, i == 3});
         rdchk(IRQ_MASKED_FLAGS_ADDR, (i == 3) ? 32'h00000800 : 32'h00000000);
         wr(IRQ_CLEAR_ADDR, 32'h0000FFFF);
      end
      daddr.tx_eof_desc <= 32'hFFFF0000;
      daddr.tx_eof_buffer <= 32'hFFFF0001;
      daddr.rx_eof_desc <= 32'hFFFF0002;
      idle(2);
      rdchk(TX_EOF_DESC_ADDR_ADDR, 32'h0A0B0C00);
      rdchk(TX_EOF_BUFFER_ADDR_ADDR, 32'h0D0E0F00);
      rdchk(RX_EOF_DESC_ADDR_ADDR, 32'h01020300);
   endtask

   task automatic trackers();
      daddr.rx_current_desc <= 32'h3FFB0010;
      daddr.rx_next_desc <= 32'h3FFB0020;
      daddr.rx_next_buffer <= 32'h3FFB0030;
      daddr.tx_current_desc <= 32'h3FFC0010;
      daddr.tx_next_desc <= 32'h3FFC0020;
      daddr.tx_next_buffer <= 32'h3FFC0030;
      idle(2);
      wr(TX_CURRENT_DESC_ADDR, 32'h00000000);
      rdchk(RX_CURRENT_DESC_ADDR, 32'h3FFB0010);
      rdchk(RX_NEXT_DESC_ADDR, 32'h3FFB0020);
      rdchk(RX_NEXT_BUFFER_ADDR, 32'h3FFB0030);
      rdchk(TX_CURRENT_DESC_ADDR, 32'h3FFC0010);
      rdchk(TX_NEXT_DESC_ADDR, 32'h3FFC0020);
      rdchk(TX_NEXT_BUFFER_ADDR, 32'h3FFC0030);
   endtask

   task automatic timeout_flags();
      wr(STALL_TIMEOUT_SETUP_ADDR, 32'h00000008);
      fifo.tx_pending <= 1'h1;
      fifo.rx_pending <= 1'h1;
      idle(20);
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000000);
      wr(STALL_TIMEOUT_SETUP_ADDR, 32'h00003008);
      repeat (6) begin
         fifo.tx_xfer <= 1'h1;
         fifo.rx_xfer <= 1'h1;
         @(posedge sys_clk);
         fifo.tx_xfer <= 1'h0;
         fifo.rx_xfer <= 1'h0;
         idle(4);
      end
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000000);
      fifo.rx_pending <= 1'h0;
      idle(12);
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000080);
      fifo.rx_pending <= 1'h1;
      wr(IRQ_CLEAR_ADDR, 32'h0000FFFF);
      idle(12);
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000040);
   endtask

   // Stored words reach their outputs, and a mid-run reset restores them
   task automatic mid_reset();
      wr(MAIN_CONTROL_ADDR, 32'hA5A50001);
      wr(TX_CHAIN_CONTROL_ADDR, 32'h00C0FFEE);
      wr(RX_CHAIN_CONTROL_ADDR, 32'h00BEEF00);
      wr(FIFO_SETUP_ADDR, 32'h00001234);
      idle(1);
      check(ctrl, 32'hA5A50001);
      check(txch, 32'h00C0FFEE);
      check(rxch, 32'h00BEEF00);
      check(fsetup, 32'h00001234);
      srst <= 1'h1;
      idle(2);
      srst <= 1'h0;
      idle(1);
      check(ctrl, 32'h00000000);
      check(txch, 32'h00000000);
      check(rxch, 32'h00000000);
      check(fsetup, 32'h00000F84);
      check({31'h0, irq}, 32'h00000000);
      rdchk(IRQ_RAW_FLAGS_ADDR, 32'h00000000);
      rdchk(STALL_TIMEOUT_SETUP_ADDR, 32'h000030FF);
   endtask

   initial begin
      idle(12);
      srst <= 1'h0;
      reset_values();
      fifo_flags();
      dma_flags();
      trackers();
      timeout_flags();
      mid_reset();
      final_report();
   end
endmodule
